//--- pkg/pdm_bridge_pkg.sv
// Shared constants for the PDM microphone to I2S bridge
`default_nettype none
package pdm_bridge_pkg;
  // Jumper codes {first, second}, 1 = closed
  localparam logic [1:0] RATE_CC = 2'h3;
  localparam logic [1:0] RATE_CO = 2'h2;
  localparam logic [1:0] RATE_OC = 2'h1;
  localparam logic [1:0] RATE_OO = 2'h0;
  // Reference clock and the mic clock with both rate jumpers closed, in kHz
  localparam int unsigned REF_OSC_KHZ = 12000;
  localparam int unsigned MIC_CLK_CC_KHZ = 2400;
  localparam int unsigned EXT_DIV = 5;
  // Half periods of the mic clock in reference edges; both edges tick
  localparam logic [3:0] HALF_CC = 4'(REF_OSC_KHZ / MIC_CLK_CC_KHZ);
  localparam logic [3:0] HALF_CO = 4'(REF_OSC_KHZ / 1600);
  // 1.6 MHz is 15 edges a period, so the low half takes the odd one
  localparam logic [3:0] HALF_CO_LO =
    4'(2 * REF_OSC_KHZ / 1600 - REF_OSC_KHZ / 1600);
  localparam logic [3:0] HALF_OC = 4'(REF_OSC_KHZ / 1200);
  localparam logic [3:0] HALF_OO = 4'(REF_OSC_KHZ / 800);
  // External reference over five: five edges each half
  localparam logic [2:0] EXT_HALF_HI = 3'(EXT_DIV);
  localparam logic [2:0] EXT_HALF_LO = 3'(EXT_DIV);
  // Decimation and I2S framing
  localparam int unsigned DECIM = 50;
  localparam logic [5:0] DECIM_LAST = 6'(DECIM - 1);
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned SLOT_BITS = 25;
  localparam logic [4:0] SLOT_LAST = 5'(SLOT_BITS - 1);
  localparam int unsigned ACC_W = 16;
  localparam int unsigned FIFO_W = 48;
  localparam int unsigned FIFO_D = 32;
  localparam logic [15:0] ACC_RST = 16'h0000;
endpackage
`default_nettype wire

//--- verilog/sample_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none
module sample_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_r[rd_r];

  always_ff @(posedge i_clk_sys)
  begin
    if (push)
    begin
      mem_r[wr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (pop)
        rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- verilog/pdm_i2s_bridge.sv
// PDM microphone clocking, decimation and I2S output bridge
//
// Operation
// RULE_01: Two rate jumpers pick mic clock 2.4/1.6/1.2/0.8 MHz, 48/32/24/16 kHz.
// RULE_02: External reference, both jumpers closed: mic clock is reference over five.
// RULE_03: Source jumper picks 12 MHz oscillator or external reference clock.
// RULE_04: Input jumper routes on-board pair or socket plus connector.
// RULE_05: Connector carries clock and data for one or two microphones.
// RULE_06: Monitor pins copy the microphone clock and PDM data.
// RULE_07: Device drives I2S data, bit clock and frame clock as source.
// RULE_08: Two 25-bit channels per frame, 24-bit samples MSB first.
// RULE_09: Stereo mics drive on opposite edges; each sampled on other phase.
// RULE_10: Two decimation filters, one per stereo channel.
// RULE_11: Each filter decimates by fifty, one sample per frame.
`default_nettype none
module pdm_i2s_bridge (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_osc_12m,
  input wire logic i_external_clock_input,
  input wire logic i_clock_source_jumper,
  input wire logic [1:0] i_clock_rate_jumpers,
  input wire logic i_input_source_jumpers,
  input wire logic i_onboard_data_a,
  input wire logic i_onboard_data_b,
  input wire logic i_socketed_part_data,
  input wire logic i_external_mic_connector_data,
  output logic o_onboard_clk,
  output logic o_socketed_part_clk,
  output logic o_external_mic_connector_clk,
  output logic o_monitor_header_clk,
  output logic o_monitor_header_data,
  output logic o_i2s_sd,
  output logic o_i2s_bclk,
  output logic o_i2s_lrclk,
  output logic o_fifo_overflow
);
  ////////////////////////////////////////////////////////////////////////
  // Reference tick selection
  logic ref_osc_r;
  logic ref_ext_r;
  logic ref_sel;
  logic ref_tick;
  logic ref_prev_r;

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ref_osc_r <= 1'b0;
      ref_ext_r <= 1'b0;
      ref_prev_r <= 1'b0;
    end
    else
    begin
      ref_osc_r <= i_osc_12m;
      ref_ext_r <= i_external_clock_input;
      ref_prev_r <= ref_sel;
    end
  end

  // Both reference edges tick, so 1.6 MHz divides out exactly
  assign ref_sel = i_clock_source_jumper ? ref_ext_r : ref_osc_r; // RULE_03
  assign ref_tick = ref_sel ^ ref_prev_r;

  ////////////////////////////////////////////////////////////////////////
  // Microphone clock divider
  logic [3:0] half_lim;
  logic [3:0] div_r;
  logic mclk_r;
  logic mclk_rise;
  logic mclk_fall;

  always_comb
  begin
    if (i_clock_source_jumper && i_clock_rate_jumpers == pdm_bridge_pkg::RATE_CC)
      half_lim = mclk_r ? 4'(pdm_bridge_pkg::EXT_HALF_HI)
                        : 4'(pdm_bridge_pkg::EXT_HALF_LO); // RULE_02
    else
    begin
      case (i_clock_rate_jumpers) // RULE_01
        pdm_bridge_pkg::RATE_CC: half_lim = pdm_bridge_pkg::HALF_CC;
        pdm_bridge_pkg::RATE_CO: half_lim = mclk_r ? pdm_bridge_pkg::HALF_CO
          : pdm_bridge_pkg::HALF_CO_LO;
        pdm_bridge_pkg::RATE_OC: half_lim = pdm_bridge_pkg::HALF_OC;
        default: half_lim = pdm_bridge_pkg::HALF_OO;
      endcase
    end
  end

  assign mclk_rise = ref_tick && (div_r + 4'h1 >= half_lim) && !mclk_r;
  assign mclk_fall = ref_tick && (div_r + 4'h1 >= half_lim) && mclk_r;

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      div_r <= 4'h0;
      mclk_r <= 1'b0;
    end
    else if (ref_tick)
    begin
      if (div_r + 4'h1 >= half_lim)
      begin
        div_r <= 4'h0;
        mclk_r <= !mclk_r;
      end
      else
        div_r <= div_r + 4'h1;
    end
  end

  // Clock goes to both source groups, shared by a stereo pair
  assign o_onboard_clk = mclk_r; // RULE_05
  assign o_socketed_part_clk = mclk_r;
  assign o_external_mic_connector_clk = mclk_r;

  ////////////////////////////////////////////////////////////////////////
  // Input routing and phase sampling
  logic pdm_data;
  logic left_bit_r;
  logic right_bit_r;
  logic mon_data_r;

  always_comb
  begin
    if (i_input_source_jumpers) // RULE_04
      pdm_data = i_socketed_part_data | i_external_mic_connector_data;
    else
      pdm_data = i_onboard_data_a | i_onboard_data_b;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      left_bit_r <= 1'b0;
      right_bit_r <= 1'b0;
      mon_data_r <= 1'b0;
    end
    else
    begin
      // Rising-edge talker is stable by the falling edge, and vice versa
      if (mclk_fall)
        left_bit_r <= pdm_data; // RULE_09
      if (mclk_rise)
        right_bit_r <= pdm_data; // RULE_09
      mon_data_r <= pdm_data;
    end
  end

  assign o_monitor_header_clk = mclk_r; // RULE_06
  assign o_monitor_header_data = mon_data_r; // RULE_06

  ////////////////////////////////////////////////////////////////////////
  // Decimation: boxcar count of ones over fifty bits per channel
  logic [5:0] dec_cnt_r;
  logic dec_done;
  logic [pdm_bridge_pkg::ACC_W-1:0] acc_r [2];
  logic [pdm_bridge_pkg::SAMPLE_W-1:0] pcm [2];
  logic [1:0] new_bit;

  assign new_bit = {right_bit_r, left_bit_r};
  assign dec_done = mclk_rise && (dec_cnt_r == pdm_bridge_pkg::DECIM_LAST);

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      dec_cnt_r <= 6'h00;
    else if (mclk_rise)
      dec_cnt_r <= dec_done ? 6'h00 : dec_cnt_r + 6'h01; // RULE_11
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_decim // RULE_10
      always_ff @(posedge i_clk_sys or negedge i_nrst)
      begin
        if (!i_nrst)
          acc_r[ch] <= pdm_bridge_pkg::ACC_RST;
        else if (mclk_rise)
          acc_r[ch] <= dec_done ? 16'(new_bit[ch])
                                : acc_r[ch] + 16'(new_bit[ch]); // RULE_11
      end
      // Map 0..50 ones to signed: (2*ones - 50) scaled up; coarse but exact
      assign pcm[ch] = 24'((32'(acc_r[ch]) * 2 - 32'(pdm_bridge_pkg::DECIM))
                           <<< 17);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Sample FIFO
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [pdm_bridge_pkg::FIFO_W-1:0] fifo_out;
  logic ovf_r;

  sample_fifo #(
    .WIDTH(pdm_bridge_pkg::FIFO_W),
    .DEPTH(pdm_bridge_pkg::FIFO_D)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_in_valid(dec_done),
    .o_in_ready(fifo_in_ready),
    .i_in_data({pcm[0], pcm[1]}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out)
  );

  // A full FIFO drops the sample; the flag stays until reset
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      ovf_r <= 1'b0;
    else if (dec_done && !fifo_in_ready)
      ovf_r <= 1'b1;
  end
  assign o_fifo_overflow = ovf_r;

  ////////////////////////////////////////////////////////////////////////
  // I2S transmitter: bit clock equals mic clock, 50 bits per frame
  logic [4:0] bit_r;
  logic lr_r;
  logic [pdm_bridge_pkg::FIFO_W-1:0] frame_r;
  logic [pdm_bridge_pkg::SAMPLE_W-1:0] shift_r;
  logic sd_r;
  logic frame_end;

  assign frame_end = mclk_fall && lr_r && (bit_r == pdm_bridge_pkg::SLOT_LAST);
  assign fifo_pop = frame_end && fifo_out_valid;

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bit_r <= 5'h00;
      lr_r <= 1'b0;
      frame_r <= '0;
      shift_r <= '0;
      sd_r <= 1'b0;
    end
    else if (mclk_fall) // RULE_07
    begin
      if (bit_r == pdm_bridge_pkg::SLOT_LAST)
      begin
        bit_r <= 5'h00;
        lr_r <= !lr_r;
        sd_r <= 1'b0;
        // Underrun repeats the previous frame rather than emitting junk
        if (frame_end && fifo_out_valid)
          frame_r <= fifo_out;
        shift_r <= lr_r ? (fifo_out_valid ? fifo_out[47:24] : frame_r[47:24])
                        : frame_r[23:0];
      end
      else
      begin
        bit_r <= bit_r + 5'h01; // RULE_08
        sd_r <= shift_r[pdm_bridge_pkg::SAMPLE_W-1];
        shift_r <= {shift_r[pdm_bridge_pkg::SAMPLE_W-2:0], 1'b0}; // RULE_08
      end
    end
  end

  assign o_i2s_bclk = mclk_r;
  assign o_i2s_lrclk = lr_r;
  assign o_i2s_sd = sd_r;
endmodule
`default_nettype wire

//--- tb/pdm_bridge_sva.sv
// Port checker for the PDM to I2S bridge
`default_nettype none
module pdm_bridge_sva (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_osc_12m,
  input wire logic i_external_clock_input,
  input wire logic i_clock_source_jumper,
  input wire logic [1:0] i_clock_rate_jumpers,
  input wire logic i_input_source_jumpers,
  input wire logic i_onboard_data_a,
  input wire logic i_onboard_data_b,
  input wire logic i_socketed_part_data,
  input wire logic i_external_mic_connector_data,
  input wire logic o_onboard_clk,
  input wire logic o_socketed_part_clk,
  input wire logic o_external_mic_connector_clk,
  input wire logic o_monitor_header_clk,
  input wire logic o_monitor_header_data,
  input wire logic o_i2s_sd,
  input wire logic o_i2s_bclk,
  input wire logic o_i2s_lrclk
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////
  logic ref_q, mclk_q, lr_q, seen_r, lseen_r;
  logic [3:0] tk_r;
  logic [5:0] fl_r;
  logic [3:0] half;
  wire logic rsel = i_clock_source_jumper ? i_external_clock_input
    : i_osc_12m;
  // Any reference edge is one tick
  wire logic rise = rsel ^ ref_q;
  wire logic tog = o_onboard_clk ^ mclk_q;
  wire logic lrt = o_i2s_lrclk ^ lr_q;
  wire logic fall = mclk_q & ~o_onboard_clk;
  wire logic dsel = i_input_source_jumpers
    ? (i_socketed_part_data | i_external_mic_connector_data)
    : (i_onboard_data_a | i_onboard_data_b);
  always_comb
  begin
    case (i_clock_rate_jumpers)
      pdm_bridge_pkg::RATE_CC: half = pdm_bridge_pkg::HALF_CC;
      pdm_bridge_pkg::RATE_CO: half = mclk_q ? pdm_bridge_pkg::HALF_CO
        : pdm_bridge_pkg::HALF_CO_LO;
      pdm_bridge_pkg::RATE_OC: half = pdm_bridge_pkg::HALF_OC;
      default: half = pdm_bridge_pkg::HALF_OO;
    endcase
    // External reference over five: five edges each half
    if (i_clock_source_jumper
      && i_clock_rate_jumpers == pdm_bridge_pkg::RATE_CC)
      half = mclk_q ? 4'(pdm_bridge_pkg::EXT_HALF_HI)
        : 4'(pdm_bridge_pkg::EXT_HALF_LO);
  end
  // First interval after reset is partial, so it is skipped
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      {ref_q, mclk_q, lr_q, seen_r, lseen_r} <= 5'h00;
      tk_r <= 4'h0;
      fl_r <= 6'h00;
    end
    else
    begin
      {ref_q, mclk_q, lr_q} <= {rsel, o_onboard_clk, o_i2s_lrclk};
      tk_r <= tog ? 4'(rise) : tk_r + 4'(rise);
      fl_r <= lrt ? 6'(fall) : fl_r + 6'(fall);
      seen_r <= seen_r | tog;
      lseen_r <= lseen_r | lrt;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_bfall;
    $fell(o_i2s_bclk);
  endsequence
  sequence s_slot_end;
    lrt && lseen_r;
  endsequence
  AST_MIC_HALF: assert property (tog && seen_r |-> tk_r == half)
    else $error("mic clock half period wrong");
  AST_CLK_FAN: assert property (o_socketed_part_clk == o_onboard_clk
    && o_external_mic_connector_clk == o_onboard_clk)
    else $error("mic clock outputs differ");
  AST_MON_CLK: assert property (o_monitor_header_clk == o_onboard_clk)
    else $error("monitor clock differs");
  AST_MON_DATA: assert property ($past(i_nrst, 2) |->
    o_monitor_header_data == $past(dsel)) else $error("monitor data wrong");
  AST_BCLK: assert property (o_i2s_bclk == o_onboard_clk)
    else $error("bit clock differs");
  AST_SD_HOLD: assert property ($changed(o_i2s_sd) |-> s_bfall)
    else $error("data moved off a falling bit clock");
  AST_LR_HOLD: assert property ($changed(o_i2s_lrclk) |-> s_bfall)
    else $error("frame clock moved off a falling bit clock");
  AST_SLOT_LEN: assert property (s_slot_end |-> fl_r == 6'h19)
    else $error("slot length wrong");
endmodule
bind pdm_i2s_bridge pdm_bridge_sva u_sva (.*);
`default_nettype wire

//--- tb/pdm_partner_model.sv
// Microphone pair and I2S receiver models
`default_nettype none
module mic_pair (
  input wire logic i_clk,
  input wire logic i_lvl_r,
  input wire logic i_lvl_f,
  output logic o_dr,
  output logic o_df
);
  // Released half idles low so the shared-line OR stays clean
  assign o_dr = i_clk & i_lvl_r;
  assign o_df = ~i_clk & i_lvl_f;
endmodule
module i2s_rx (
  input wire logic i_bclk,
  input wire logic i_lr,
  input wire logic i_sd,
  output logic [23:0] o_left,
  output logic [23:0] o_right
);
  logic [24:0] sh = 25'h0;
  logic lr_q = 1'b0;
  always @(posedge i_bclk)
  begin
    if (i_lr != lr_q && lr_q)
      o_right <= sh[23:0];
    if (i_lr != lr_q && !lr_q)
      o_left <= sh[23:0];
    sh <= {sh[23:0], i_sd};
    lr_q <= i_lr;
  end
endmodule
`default_nettype wire

//--- tb/pdm_i2s_bridge_tb.sv
// Self-checking bench for the PDM to I2S bridge
`default_nettype none
module pdm_i2s_bridge_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 0, i_nrst = 0, i_osc_12m = 0, i_external_clock_input = 0;
  logic i_clock_source_jumper = 0, i_input_source_jumpers = 0;
  logic [1:0] i_clock_rate_jumpers = 2'h3;
  logic i_onboard_data_a, i_onboard_data_b, i_socketed_part_data;
  logic i_external_mic_connector_data, o_onboard_clk, o_socketed_part_clk;
  logic o_external_mic_connector_clk, o_monitor_header_clk, o_i2s_sd;
  logic o_monitor_header_data, o_i2s_bclk, o_i2s_lrclk, o_fifo_overflow;
  logic la = 0, lb = 0, ls = 0, lc = 0;
  logic [23:0] left, right;
  int n_errors = 0, checks_done = 0;
  pdm_i2s_bridge DUT (.*);
  mic_pair m_on (.i_clk(o_onboard_clk), .i_lvl_r(la), .i_lvl_f(lb),
    .o_dr(i_onboard_data_a), .o_df(i_onboard_data_b));
  mic_pair m_ex (.i_clk(o_socketed_part_clk), .i_lvl_r(ls), .i_lvl_f(lc),
    .o_dr(i_socketed_part_data), .o_df(i_external_mic_connector_data));
  i2s_rx rx (.i_bclk(o_i2s_bclk), .i_lr(o_i2s_lrclk), .i_sd(o_i2s_sd),
    .o_left(left), .o_right(right));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // Scaled references: oscillator period 4 cycles, external 2
  always @(posedge i_clk_sys)
  begin
    i_external_clock_input <= ~i_external_clock_input;
    if (i_external_clock_input)
      i_osc_12m <= ~i_osc_12m;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [23:0] smp(input logic l);
    return 24'((l ? 50 : -50) * 131072);
  endfunction
  task automatic setup(input logic s, input logic [1:0] r, input logic i);
    @(posedge i_clk_sys);
    i_nrst <= 1'b0;
    {i_clock_source_jumper, i_clock_rate_jumpers} <= {s, r};
    i_input_source_jumpers <= i;
    repeat (4) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
  endtask
  task automatic widths(output int hi, output int lo);
    wait (o_onboard_clk === 1'b1);
    wait (o_onboard_clk === 1'b0);
    {hi, lo} = 0;
    while (o_onboard_clk !== 1'b1)
    begin
      @(posedge i_clk_sys) #1 lo++;
    end
    while (o_onboard_clk === 1'b1)
    begin
      @(posedge i_clk_sys) #1 hi++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_rates;
    int hi, lo, per;
    int khz [4] = '{800, 1200, 1600, 2400};
    for (int r = 0; r < 4; r++)
    begin
      {la, lb, ls, lc} <= {r[0], ~r[0], ~r[0], r[0]};
      setup(1'b0, 2'(r), 1'b0);
      // Oscillator period is four system cycles
      per = 48000 / khz[r];
      widths(hi, lo);
      check(24'(hi + lo), 24'(per));
      check(24'(hi), 24'(2 * (12000 / khz[r])));
      repeat (200 * per) @(posedge i_clk_sys);
      check(left, smp(r[0]));
      check(right, smp(~r[0]));
      check(24'(o_fifo_overflow), 24'h0);
    end
  endtask
  task automatic t_sock_ext;
    int hi, lo;
    {la, lb, ls, lc} <= 4'h6;
    setup(1'b0, 2'h3, 1'b1);
    repeat (4800) @(posedge i_clk_sys);
    check(left, smp(1'b1));
    check(right, smp(1'b0));
    setup(1'b1, 2'h3, 1'b1);
    widths(hi, lo);
    check(24'(hi + lo), 24'(5 * 2));
  endtask
  // Sample path through the FIFO: a level change must reach the output
  task automatic t_fifo;
    {la, lb} <= 2'h3;
    setup(1'b0, 2'h3, 1'b0);
    repeat (4000) @(posedge i_clk_sys);
    check(left, smp(1'b1));
    la <= 1'b0;
    repeat (4000) @(posedge i_clk_sys);
    check(left, smp(1'b0));
    check(right, smp(1'b1));
    check(24'(o_fifo_overflow), 24'h0);
  endtask
  initial
  begin
    t_rates();
    t_sock_ext();
    t_fifo();
    conclude();
  end
  initial
  begin
    repeat (60000) @(posedge i_clk_sys);
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
